// ==== verilog/dpd_cfg.svh ====
`ifndef DPD_CFG_SVH
`define DPD_CFG_SVH
// Period counter geometry
`define DPD_CNT_W 10
`define DPD_PERIOD 1024
// Helper clock count seen at a wrap: 2048 clocks per period, less one
`define DPD_WRAP_GAP 12'h7ff
// Count width that can hold 1024
`define DPD_DUTY_W 11
// Clamp limits, both channels
`define DPD_LOW_MAX 11'h07a
`define DPD_GEN_HIGH_MIN 11'h2e7
`define DPD_REF_HIGH_MIN 11'h386
// Hold-off limit for the reference pin, in microseconds
`define DPD_HOLD_US 1000
`define DPD_CLK_MHZ 10
`define DPD_HOLD_CYC (`DPD_HOLD_US * `DPD_CLK_MHZ)
// Precharge burst length in periods
`define DPD_PRE_PERIODS 8'h08
`endif

// ==== verilog/dpd_pkg.sv ====
package dpd_pkg;
    typedef enum logic [1:0] {
        DPD_DRIVE,
        DPD_HOLD
    } dpd_ref_state_t;
endpackage : dpd_pkg

// ==== verilog/dpd_top.sv ====
`timescale 1ns/1ps
`include "dpd_cfg.svh"
module dpd_top #(
    parameter int HOLD_CYC = `DPD_HOLD_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic [`DPD_DUTY_W-1:0] gen_duty,
    input wire logic gen_load,
    input wire logic [`DPD_DUTY_W-1:0] ref_duty,
    input wire logic ref_load,
    input wire logic precharge_en,
    input wire logic hold_req,
    output logic general_pwm_pin,
    output logic reference_pwm_out,
    output logic reference_pwm_oe,
    output logic precharge_pwm_pin,
    output logic precharge_pwm_oe,
    output logic period_start
);
    localparam int HW = $clog2(HOLD_CYC + 1);
    localparam logic [HW-1:0] HOLD_MAX = HW'(HOLD_CYC);

    logic div_r, div_nxt;
    logic [`DPD_CNT_W-1:0] cnt_r, cnt_nxt;
    logic [`DPD_DUTY_W-1:0] gen_pend_r, gen_pend_nxt, gen_act_r, gen_act_nxt;
    logic [`DPD_DUTY_W-1:0] ref_pend_r, ref_pend_nxt, ref_act_r, ref_act_nxt;
    logic gen_out_r, gen_out_nxt, ref_out_r, ref_out_nxt;
    logic pre_out_r, pre_out_nxt, pre_oe_r, pre_oe_nxt;
    logic ref_oe_r, ref_oe_nxt, per_r, per_nxt;
    logic [7:0] pre_cnt_r, pre_cnt_nxt;
    logic [HW-1:0] hold_r, hold_nxt;
    dpd_pkg::dpd_ref_state_t st_r, st_nxt;
    logic tick, wrap, gen_lvl, ref_lvl;

    always_comb begin
        tick = div_r;
        wrap = tick && (cnt_r == '1);
        div_nxt = ~div_r;
        cnt_nxt = tick ? cnt_r + 1'b1 : cnt_r;
        gen_pend_nxt = gen_load ? gen_duty : gen_pend_r;
        ref_pend_nxt = ref_load ? ref_duty : ref_pend_r;
        // Active counts swap only at the wrap so a pulse is never cut short
        // A load taken on the wrap edge itself still makes this boundary
        gen_act_nxt = wrap ? gen_pend_nxt : gen_act_r;
        ref_act_nxt = wrap ? ref_pend_nxt : ref_act_r;
        // Clamp first, then compare against the shared counter
        // The coming count is used so count 0 of a new period never shows the old duty
        if (gen_act_nxt <= `DPD_LOW_MAX) begin
            gen_lvl = 1'b0;
        end else if (gen_act_nxt >= `DPD_GEN_HIGH_MIN) begin
            gen_lvl = 1'b1;
        end else begin
            gen_lvl = {1'b0, cnt_nxt} < gen_act_nxt;
        end
        if (ref_act_nxt <= `DPD_LOW_MAX) begin
            ref_lvl = 1'b0;
        end else if (ref_act_nxt >= `DPD_REF_HIGH_MIN) begin
            ref_lvl = 1'b1;
        end else begin
            ref_lvl = {1'b0, cnt_nxt} < ref_act_nxt;
        end
        // The general and reference pins move only on a counter tick, mirroring a timer-driven port load
        gen_out_nxt = tick ? gen_lvl : gen_out_r;
        ref_out_nxt = tick ? ref_lvl : ref_out_r;
        per_nxt = wrap;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            div_r <= 1'b0;
            cnt_r <= '0;
            gen_pend_r <= '0;
            gen_act_r <= '0;
            ref_pend_r <= '0;
            ref_act_r <= '0;
            gen_out_r <= 1'b0;
            ref_out_r <= 1'b0;
            per_r <= 1'b0;
        end else begin
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
            gen_pend_r <= gen_pend_nxt;
            gen_act_r <= gen_act_nxt;
            ref_pend_r <= ref_pend_nxt;
            ref_act_r <= ref_act_nxt;
            gen_out_r <= gen_out_nxt;
            ref_out_r <= ref_out_nxt;
            per_r <= per_nxt;
        end
    end

    // Precharge burst: follows the reference waveform for a few periods after a load
    always_comb begin
        pre_cnt_nxt = pre_cnt_r;
        if (ref_load && precharge_en) begin
            pre_cnt_nxt = `DPD_PRE_PERIODS;
        end else if (wrap && pre_cnt_r != 8'h00) begin
            pre_cnt_nxt = pre_cnt_r - 8'h01;
        end
        pre_oe_nxt = pre_cnt_nxt != 8'h00;
        pre_out_nxt = pre_oe_nxt ? ref_out_nxt : 1'b0;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            pre_cnt_r <= 8'h00;
            pre_oe_r <= 1'b0;
            pre_out_r <= 1'b0;
        end else begin
            pre_cnt_r <= pre_cnt_nxt;
            pre_oe_r <= pre_oe_nxt;
            pre_out_r <= pre_out_nxt;
        end
    end

    // Hold: float the reference pin; forced back after the limit even if still asked
    always_comb begin
        st_nxt = st_r;
        hold_nxt = hold_r;
        case (st_r)
            dpd_pkg::DPD_DRIVE: begin
                hold_nxt = '0;
                if (hold_req) begin
                    st_nxt = dpd_pkg::DPD_HOLD;
                end
            end
            dpd_pkg::DPD_HOLD: begin
                hold_nxt = hold_r + 1'b1;
                if (!hold_req || hold_r >= HOLD_MAX - 1'b1) begin
                    st_nxt = dpd_pkg::DPD_DRIVE;
                end
            end
            default: st_nxt = dpd_pkg::DPD_DRIVE;
        endcase
        // A released hold needs a fresh request, stopping an endless float
        if (st_r == dpd_pkg::DPD_DRIVE && hold_r != '0) begin
            st_nxt = dpd_pkg::DPD_DRIVE;
        end
        ref_oe_nxt = st_nxt == dpd_pkg::DPD_DRIVE;
    end

    logic rearm_r, rearm_nxt;
    always_comb begin
        rearm_nxt = (st_r == dpd_pkg::DPD_HOLD && st_nxt == dpd_pkg::DPD_DRIVE) ||
                    (rearm_r && hold_req);
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            st_r <= dpd_pkg::DPD_DRIVE;
            hold_r <= '0;
            ref_oe_r <= 1'b1;
            rearm_r <= 1'b0;
        end else begin
            st_r <= rearm_r ? dpd_pkg::DPD_DRIVE : st_nxt;
            hold_r <= hold_nxt;
            ref_oe_r <= rearm_r ? 1'b1 : ref_oe_nxt;
            rearm_r <= rearm_nxt;
        end
    end

    assign general_pwm_pin = gen_out_r;
    assign reference_pwm_out = ref_out_r;
    assign reference_pwm_oe = ref_oe_r;
    assign precharge_pwm_pin = pre_out_r;
    assign precharge_pwm_oe = pre_oe_r;
    assign period_start = per_r;

    // Clocks since the last wrap; checks the period without a very long delay range
    logic [11:0] per_clk_r, per_clk_nxt;
    always_comb begin
        per_clk_nxt = wrap ? 12'h000 : per_clk_r + 12'h001;
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            per_clk_r <= 12'h000;
        end else begin
            per_clk_r <= per_clk_nxt;
        end
    end

    sequence wrap_seq;
        wrap;
    endsequence

    counter_step_a: assert property (@(posedge clock) disable iff (!nrst)
        tick |=> (cnt_r == $past(cnt_r) + 1'b1) ##1 (cnt_r == $past(cnt_r)))
        else $error("period counter did not step every second clock");
    counter_wrap_a: assert property (@(posedge clock) disable iff (!nrst)
        wrap_seq |-> (per_clk_r == `DPD_WRAP_GAP) ##1 (cnt_r == '0))
        else $error("period is not 2048 clocks");
    pin_hold_a: assert property (@(posedge clock) disable iff (!nrst)
        !tick |=> $stable(general_pwm_pin) && $stable(reference_pwm_out))
        else $error("pin changed between ticks");
    load_defer_a: assert property (@(posedge clock) disable iff (!nrst)
        !wrap |=> $stable(gen_act_r) && $stable(ref_act_r))
        else $error("active count changed mid period");
    gen_clamp_a: assert property (@(posedge clock) disable iff (!nrst)
        tick ##1 (gen_act_r <= `DPD_LOW_MAX) |-> !general_pwm_pin)
        else $error("general channel not clamped low");
    ref_clamp_a: assert property (@(posedge clock) disable iff (!nrst)
        tick ##1 (ref_act_r >= `DPD_REF_HIGH_MIN) |-> reference_pwm_out)
        else $error("reference channel not clamped high");
    gen_compare_a: assert property (@(posedge clock) disable iff (!nrst)
        tick ##1 (gen_act_r > `DPD_LOW_MAX && gen_act_r < `DPD_GEN_HIGH_MIN)
        |-> general_pwm_pin == ({1'b0, cnt_r} < gen_act_r))
        else $error("general level disagrees with counter");
    hold_limit_a: assert property (@(posedge clock) disable iff (!nrst)
        st_r == dpd_pkg::DPD_HOLD |-> hold_r < HOLD_MAX)
        else $error("reference float exceeded limit");
    precharge_a: assert property (@(posedge clock) disable iff (!nrst)
        ref_load && precharge_en |=> precharge_pwm_oe)
        else $error("precharge not started");
endmodule : dpd_top

// ==== tb/dpd_rc_model.sv ====
`timescale 1ns/1ps
// Filter stage as an averager: high clocks per period give the settled level
module dpd_rc_model (
    input wire logic clock,
    input wire logic nrst,
    input wire logic drive,
    input wire logic oe,
    input wire logic frame,
    output int high_cnt
);
    // A floating pin leaves the capacitor at its last driven level
    logic cap_r;
    int acc;
    always @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            cap_r <= 1'b0;
            acc <= 0;
            high_cnt <= 0;
        end else begin
            if (oe) begin
                cap_r <= drive;
            end
            if (frame) begin
                high_cnt <= acc;
                acc <= int'(oe ? drive : cap_r);
            end else begin
                acc <= acc + int'(oe ? drive : cap_r);
            end
        end
    end
endmodule : dpd_rc_model

// ==== tb/test_dual_pwm_dac_driver.sv ====
`timescale 1ns/1ps
module test_dual_pwm_dac_driver;
    localparam int HOLD = 50;
    logic clock = 1'b0;
    logic nrst = 1'b0;
    logic [10:0] gen_duty = 11'h000;
    logic [10:0] ref_duty = 11'h000;
    logic gen_load = 1'b0;
    logic ref_load = 1'b0;
    logic precharge_en = 1'b0;
    logic hold_req = 1'b0;
    logic general_pwm_pin, reference_pwm_out, reference_pwm_oe;
    logic precharge_pwm_pin, precharge_pwm_oe, period_start;
    int gen_cnt, ref_cnt, n, eg = 0, er = 0, failures = 0, total_checks = 0;
    int duties[10] = '{0, 122, 123, 256, 512, 742, 743, 901, 902, 1024};
    always #50 clock = ~clock;
    dpd_top #(.HOLD_CYC(HOLD)) dut_u (.clock(clock), .nrst(nrst), .gen_duty(gen_duty),
        .gen_load(gen_load), .ref_duty(ref_duty), .ref_load(ref_load),
        .precharge_en(precharge_en), .hold_req(hold_req), .general_pwm_pin(general_pwm_pin),
        .reference_pwm_out(reference_pwm_out), .reference_pwm_oe(reference_pwm_oe),
        .precharge_pwm_pin(precharge_pwm_pin), .precharge_pwm_oe(precharge_pwm_oe),
        .period_start(period_start));
    dpd_rc_model gen_u (.clock(clock), .nrst(nrst), .drive(general_pwm_pin), .oe(1'b1),
        .frame(period_start), .high_cnt(gen_cnt));
    dpd_rc_model ref_u (.clock(clock), .nrst(nrst), .drive(reference_pwm_out),
        .oe(reference_pwm_oe), .frame(period_start), .high_cnt(ref_cnt));
    function automatic int expect_hi(int d, int top);
        if (d <= 122) return 0;
        if (d >= top) return 2048;
        return 2 * d;
    endfunction : expect_hi
    task automatic test_done;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done
    task automatic chk(input bit ok, input string what);
        total_checks++;
        if (!ok) begin
            failures++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : chk
    task automatic wait_ps;
        for (n = 0; n < 2100; n++) begin
            @(negedge clock);
            if (period_start === 1'b1) return;
        end
        chk(1'b0, "no period start");
        test_done();
    endtask : wait_ps
    initial begin
        void'($urandom(61));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            // Loads land mid-period to catch an early switch
            repeat ($urandom_range(1500)) @(posedge clock);
            gen_duty <= 11'(i < 10 ? duties[i] : $urandom_range(2047));
            ref_duty <= 11'(i < 10 ? duties[9 - i] : $urandom_range(1024));
            gen_load <= 1'b1;
            ref_load <= 1'b1;
            @(posedge clock);
            gen_load <= 1'b0;
            ref_load <= 1'b0;
            wait_ps();
            @(negedge clock);
            chk(gen_cnt == eg && ref_cnt == er, "load hit running period");
            eg = expect_hi(int'(gen_duty), 743);
            er = expect_hi(int'(ref_duty), 902);
            wait_ps();
            @(negedge clock);
            chk(gen_cnt == eg, "general high time");
            chk(ref_cnt == er, "reference high time");
        end
        @(posedge clock);
        hold_req <= 1'b1;
        repeat (2) @(negedge clock);
        chk(reference_pwm_oe === 1'b0, "pin still driven");
        for (n = 0; n < HOLD + 10 && reference_pwm_oe !== 1'b1; n++) begin
            @(negedge clock);
        end
        chk(n >= HOLD - 3 && n <= HOLD + 3, "float time");
        @(posedge clock);
        hold_req <= 1'b0;
        repeat (2) @(posedge clock);
        hold_req <= 1'b1;
        repeat (4) @(posedge clock);
        @(negedge clock);
        chk(reference_pwm_oe === 1'b0, "second hold not taken");
        @(posedge clock);
        hold_req <= 1'b0;
        repeat (3) @(negedge clock);
        chk(reference_pwm_oe === 1'b1, "pin not back after release");
        @(posedge clock);
        precharge_en <= 1'b1;
        ref_duty <= 11'h200;
        ref_load <= 1'b1;
        @(posedge clock);
        ref_load <= 1'b0;
        for (n = 0; n < 4200 && precharge_pwm_oe !== 1'b1; n++) begin
            @(negedge clock);
        end
        chk(precharge_pwm_oe === 1'b1, "no precharge drive");
        chk(precharge_pwm_pin === reference_pwm_out, "precharge waveform");
        test_done();
    end
endmodule : test_dual_pwm_dac_driver
